// [bench/csl_chk.sv]
/* assertions on the sync monitor ports.
   assumes binding onto csl_monitor. */
`timescale 1ns/10ps
module csl_chk (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // monitor ports
   input wire word_valid,
   input wire word_err,
   input wire delim_pulse,
   input wire loss_of_sync_status,
   input wire [4:0] sync_state_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_status_tracks_e: assert property (
      loss_of_sync_status == sync_state_q[4])
      else $error("status not tied to state E");
   a_state_onehot: assert property (
      $onehot(sync_state_q))
      else $error("state not one-hot");
   a_leave_by_delim: assert property (
      $fell(sync_state_q[4]) |-> $past(delim_pulse))
      else $error("left E without delimiter");
   a_leave_e_to_a: assert property (
      $fell(sync_state_q[4]) |-> sync_state_q[0])
      else $error("left E to other than A");
   a_change_cause: assert property (
      $changed(sync_state_q) |-> $past(delim_pulse) ||
      $past(word_valid, 2) || $past(word_valid, 3))
      else $error("state moved without cause");
   a_step_one: assert property (
      $changed(sync_state_q) && !$past(sync_state_q[4]) |->
      sync_state_q == $past(sync_state_q) << 1 ||
      sync_state_q == $past(sync_state_q) >> 1)
      else $error("state jumped");
   a_enter_e_from_d: assert property (
      $rose(sync_state_q[4]) |-> $past(sync_state_q[3]))
      else $error("E entered not from D");
   a_reset_in_e: assert property (
      $rose(resetn) |-> loss_of_sync_status && sync_state_q[4])
      else $error("reset not in E");
endmodule
bind csl_monitor csl_chk i_csl_chk (
   .sys_clk(sys_clk),
   .resetn(resetn),
   .word_valid(word_valid),
   .word_err(word_err),
   .delim_pulse(delim_pulse),
   .loss_of_sync_status(loss_of_sync_status),
   .sync_state_q(sync_state_q)
);

// [bench/csl_monitor_tb.sv]
/* self-checking bench of the sync monitor.
   assumes csl_src drives the word and delimiter inputs of the monitor. */
`timescale 1ns/10ps
module csl_monitor_tb;
   logic sys_clk = 0;
   logic resetn = 0;
   wire word_valid, word_err, delim_pulse, loss_of_sync_status;
   wire [4:0] sync_state_q;
   int fails = 0, total_checks = 0, cyc = 0;
   always #2.5 sys_clk = ~sys_clk;
   csl_src i_csl_src (
      .sys_clk(sys_clk),
      .word_valid(word_valid),
      .word_err(word_err),
      .delim_pulse(delim_pulse)
   );
   csl_monitor i_csl_monitor (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .word_valid(word_valid),
      .word_err(word_err),
      .delim_pulse(delim_pulse),
      .loss_of_sync_status(loss_of_sync_status),
      .sync_state_q(sync_state_q)
   );
   task final_report;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // waits out the block verdict latency, then compares
   task chk(input logic [4:0] s);
      repeat (3) @(posedge sys_clk);
      #1 total_checks++;
      if ({loss_of_sync_status, sync_state_q} !== {s[4], s}) begin
         fails++;
         $display("ERROR %0t %h %h", $time, {loss_of_sync_status, sync_state_q}, {s[4], s});
      end
   endtask
   task t_acquire;
      chk(5'h10);
      i_csl_src.dlm();
      chk(5'h10);
      i_csl_src.dlm();
      chk(5'h01);
      $display("acquire done");
   endtask
   task t_errors;
      i_csl_src.blk(4'h0);
      chk(5'h01);
      i_csl_src.blk(4'h8);
      chk(5'h02);
      i_csl_src.blk(4'h0);
      chk(5'h01);
      i_csl_src.blk(4'h1);
      i_csl_src.blk(4'h2);
      i_csl_src.dlm();
      i_csl_src.blk(4'h4);
      chk(5'h08);
      i_csl_src.blk(4'h0);
      chk(5'h04);
      i_csl_src.blk(4'hF);
      i_csl_src.blk(4'h1);
      chk(5'h10);
      $display("errors done");
   endtask
   // bad block lands before the next delimiter, so the count restarts
   task t_reacq;
      i_csl_src.dlm();
      i_csl_src.blk(4'h2);
      chk(5'h10);
      i_csl_src.dlm();
      chk(5'h10);
      i_csl_src.dlm();
      chk(5'h01);
      $display("reacquire done");
   endtask
   task t_reset;
      resetn = 0;
      @(posedge sys_clk) #1 resetn = 1;
      chk(5'h10);
      i_csl_src.dlm();
      i_csl_src.dlm();
      chk(5'h01);
      $display("reset done");
   endtask
   always @(posedge sys_clk) if (++cyc > 2000) begin
      fails++;
      final_report;
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 resetn = 1;
      t_acquire;
      t_errors;
      t_reacq;
      t_reset;
      final_report;
   end
endmodule

// [bench/csl_src.sv]
/* decoder and delimiter source model for the sync monitor.
   assumes one sys_clk shared with the monitor. */
`timescale 1ns/10ps
module csl_src (
   // clock
   input wire sys_clk,
   // decoder and delimiter detector side
   output logic word_valid,
   output logic word_err,
   output logic delim_pulse
);
   // idle err level is junk: only meaningful with word_valid
   initial begin
      word_valid = 0;
      word_err = 1;
      delim_pulse = 0;
   end
   task blk(input logic [3:0] e);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk) #1;
         word_valid = 1;
         word_err = e[i];
      end
      @(posedge sys_clk) #1;
      word_valid = 0;
      word_err = 1;
   endtask
   task dlm();
      @(posedge sys_clk) #1 delim_pulse = 1;
      @(posedge sys_clk) #1 delim_pulse = 0;
   endtask
endmodule

// [hdl/csl_block_check.v]
/*
 * Codeblock grouping: folds code-violation flags of consecutive
 * codewords into one verdict per completed codeblock.
 * Assumes one word_valid per decoded codeword on sys_clk.
 */
`timescale 1ns/10ps
`include "csl_consts.vh"

module csl_block_check #(
   parameter WORDS = `CSL_BLOCK_WORDS,
   parameter CW = `CSL_WCNT_W
) (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // codeword stream
   input wire word_valid,
   input wire word_err,
   // per-block verdict
   output reg blk_done_q,
   output reg blk_bad_q
);

   reg [CW-1:0] wcnt_q;
   reg err_acc_q;
   wire last_word = (wcnt_q == WORDS[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wcnt_q <= {CW{1'b0}};
         err_acc_q <= 1'b0;
         blk_done_q <= 1'b0;
         blk_bad_q <= 1'b0;
      end else begin
         blk_done_q <= 1'b0;
         if (word_valid) begin
            if (last_word) begin
               wcnt_q <= {CW{1'b0}};
               err_acc_q <= 1'b0;
               blk_done_q <= 1'b1;
               blk_bad_q <= err_acc_q | word_err;
            end else begin
               wcnt_q <= wcnt_q + {{(CW-1){1'b0}}, 1'b1};
               err_acc_q <= err_acc_q | word_err;
            end
         end
      end
   end

endmodule

// [hdl/csl_consts.vh]
/*
 * Shared constants of the channel sync loss monitor.
 * Assumes it is included by bare name from design files.
 */
`ifndef CSL_CONSTS_VH
`define CSL_CONSTS_VH

// codewords per codeblock
`define CSL_BLOCK_WORDS 4
`define CSL_WCNT_W 2
// delimiters needed to regain sync
`define CSL_DELIM_NEED 2
`define CSL_DCNT_W 2

// one-hot state codes
`define CSL_ST_A 5'h01
`define CSL_ST_B 5'h02
`define CSL_ST_C 5'h04
`define CSL_ST_D 5'h08
`define CSL_ST_E 5'h10

`endif

// [hdl/csl_monitor.v]
/*
 * Channel sync loss monitor: five-state machine driven by codeblock
 * verdicts and frame delimiter pulses, giving a loss-of-sync status.
 * The codeword grouping lives in csl_block_check; this file holds
 * the state machine, the delimiter counter and the status flop.
 *
 * Assumes decoder and delimiter detector run on sys_clk, so their
 * outputs are used without synchronisers.
 * Assumes word_valid is high for one cycle per decoded codeword and
 * word_err is only meaningful while word_valid is high.
 * Assumes delim_pulse is a one-cycle pulse per recognised delimiter.
 * Grouping into codeblocks starts at reset and never realigns, so
 * the source must keep codeword boundaries from reset onward.
 * Latency: the fourth codeword of a block taken at edge N shows in
 * sync_state_q and loss_of_sync_status at edge N+1.
 * Delimiters outside state E are ignored; a bad block in the same
 * cycle as a delimiter discards that delimiter.
 * After reset the machine sits in E with the status raised.
 * Limitation: a lost codeword shifts every later block boundary;
 * the machine then sees bad blocks and falls to E, which is the
 * intended reaction to a misaligned lane.
 * Trade-off: at least four bad blocks are needed before the status
 * rises, so short error bursts are ridden out while a dead channel
 * is still flagged within sixteen codewords plus one cycle.
 * Reacquisition needs two delimiters in a row with no bad block in
 * between; the count restarts on every entry to E.
 * The state code is one-hot; a stray code is treated as lost sync.
 * State codes: A=01, B=02, C=04, D=08, E=10 in hex.
 * Inputs: word_valid, word_err, delim_pulse, all on sys_clk.
 * Outputs: loss_of_sync_status and the one-hot sync_state_q.
 * Reset is asynchronous and active low on resetn.
 * All outputs come straight from flip-flops.
 * No registers are reachable by software.
 */
// How it works
// - Group codewords into four-word codeblocks, judge each.
// - Any code violation makes the codeblock invalid.
// - Valid codeblocks keep the machine in state A.
// - Each invalid codeblock steps A toward E.
// - Valid codeblock in B, C, D steps back.
// - Entering E raises the loss-of-sync status.
// - Two clean delimiters in E return to A.
// - After reset start in E, status raised.
// - Block-based counting: fast, yet tolerant of bursts.
`timescale 1ns/10ps
`include "csl_consts.vh"

module csl_monitor #(
   parameter DELIM_NEED = `CSL_DELIM_NEED
) (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // from the decoder, once per codeword
   input wire word_valid,
   input wire word_err,
   // from the delimiter detector, one-cycle pulse
   input wire delim_pulse,
   // status
   output reg loss_of_sync_status,
   output reg [4:0] sync_state_q
);

   localparam [4:0] ST_A = `CSL_ST_A;
   localparam [4:0] ST_B = `CSL_ST_B;
   localparam [4:0] ST_C = `CSL_ST_C;
   localparam [4:0] ST_D = `CSL_ST_D;
   localparam [4:0] ST_E = `CSL_ST_E;

   localparam DW = `CSL_DCNT_W;
   localparam [DW-1:0] DCNT_ZERO = {DW{1'b0}};
   localparam [DW-1:0] DCNT_ONE = {{(DW-1){1'b0}}, 1'b1};
   // last count before the delimiter that completes reacquisition
   localparam [DW-1:0] DCNT_LAST = DELIM_NEED[DW-1:0] - DCNT_ONE;

   wire blk_done;
   wire blk_bad;
   reg [4:0] state_d;
   reg [`CSL_DCNT_W-1:0] dcnt_q;
   reg [`CSL_DCNT_W-1:0] dcnt_d;

   csl_block_check u_blk (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .word_valid(word_valid),
      .word_err(word_err),
      .blk_done_q(blk_done),
      .blk_bad_q(blk_bad)
   );

   wire bad_blk = blk_done & blk_bad;
   wire good_blk = blk_done & ~blk_bad;
   wire delim_last = (dcnt_q == DCNT_LAST);

   // one compare per state code
   wire [4:0] st_hit;
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_hit
         assign st_hit[g] = (sync_state_q == (5'h01 << g));
      end
   endgenerate

   wire in_d = st_hit[3];
   wire in_e = st_hit[4];
   // anything but a single known code counts as stray
   wire st_legal = |st_hit;

   // bad block wins over a delimiter in the same cycle
   wire delim_drop = in_e & bad_blk;
   wire delim_take = in_e & delim_pulse & ~bad_blk;
   wire reacquire = delim_take & delim_last;
   wire enter_e = in_d & bad_blk;
   reg status_d;

   // counting whole blocks rides out bursts but reacts within
   // four blocks to a dead channel
   always @* begin
      state_d = sync_state_q;
      case (sync_state_q)
         ST_A: begin
            if (bad_blk) begin
               state_d = ST_B;
            end else begin
               state_d = ST_A;
            end
         end
         ST_B: begin
            if (bad_blk) begin
               state_d = ST_C;
            end else if (good_blk) begin
               state_d = ST_A;
            end else begin
               state_d = ST_B;
            end
         end
         ST_C: begin
            if (bad_blk) begin
               state_d = ST_D;
            end else if (good_blk) begin
               state_d = ST_B;
            end else begin
               state_d = ST_C;
            end
         end
         ST_D: begin
            if (enter_e) begin
               state_d = ST_E;
            end else if (good_blk) begin
               state_d = ST_C;
            end else begin
               state_d = ST_D;
            end
         end
         ST_E: begin
            if (delim_drop) begin
               state_d = ST_E;
            end else if (reacquire) begin
               state_d = ST_A;
            end else begin
               state_d = ST_E;
            end
         end
         default: begin
            // stray code: fall back to lost sync
            state_d = ST_E;
         end
      endcase
   end

   // delimiters count only in E; entry to E restarts the count
   always @* begin
      dcnt_d = dcnt_q;
      if (enter_e || !st_legal) begin
         dcnt_d = DCNT_ZERO;
      end else if (delim_drop) begin
         dcnt_d = DCNT_ZERO;
      end else if (reacquire) begin
         dcnt_d = DCNT_ZERO;
      end else if (delim_take) begin
         dcnt_d = dcnt_q + DCNT_ONE;
      end else begin
         dcnt_d = dcnt_q;
      end
   end

   // status follows the next state so it rises with entry to E
   always @* begin
      status_d = (state_d == ST_E);
   end

   // state register
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_state_q <= ST_E;
      end else begin
         sync_state_q <= state_d;
      end
   end

   // delimiter counter
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dcnt_q <= DCNT_ZERO;
      end else begin
         dcnt_q <= dcnt_d;
      end
   end

   // status raised out of reset until reacquired
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         loss_of_sync_status <= 1'b1;
      end else begin
         loss_of_sync_status <= status_d;
      end
   end

endmodule
